// ---- logic/bfa_block_engine.sv ----
`timescale 1ns/100ps
`default_nettype none
// One independent 64k byte block with its own sequencer and command slot.
module bfa_block_engine (
  // Clock and reset
  input  wire logic                      ref_clk_in,
  input  wire logic                      reset_in,
  input  wire logic                      clk_en_in,
  // Command entry
  input  wire logic                      cmd_valid_in,
  input  wire bfa_pkg::bfa_cmd_s         cmd_in,
  // Read port
  input  wire logic [bfa_pkg::BLK_AW-1:0] rd_addr_in,
  output logic      [15:0]               rd_pair_out,
  // Status
  output logic                           slot_free_out,
  output logic                           busy_out,
  output logic                           done_pulse_out,
  output logic                           verify_ok_out
);
  // ==========================================================================
  // Storage and sequencer state
  logic [7:0] mem [bfa_pkg::BLOCK_BYTES];
  typedef enum logic [1:0] {BFA_ENG_IDLE, BFA_ENG_RUN, BFA_ENG_FIN} bfa_eng_e;
  bfa_eng_e                      state_ff, nxt_state;
  bfa_pkg::bfa_cmd_s             run_ff, nxt_run, pend_ff, nxt_pend;
  logic                          pend_vld_ff, nxt_pend_vld;
  logic [bfa_pkg::TMR_W-1:0]     tmr_ff, nxt_tmr;
  logic                          vok_ff, nxt_vok, done_ff, nxt_done;
  logic                          scan_ok;

  // Verify scans the whole block; kept combinational because it is a model
  // of the array sense path rather than a timed walk.
  always_comb begin
    scan_ok = 1'b1;
    for (int i = 0; i < bfa_pkg::BLOCK_BYTES; i++) begin
      if (mem[i] != bfa_pkg::ERASED_BYTE) scan_ok = 1'b0;
    end
  end

  // Next state: one command pending behind the running one.
  always_comb begin
    nxt_state    = state_ff;
    nxt_run      = run_ff;
    nxt_pend     = pend_ff;
    nxt_pend_vld = pend_vld_ff;
    nxt_tmr      = tmr_ff;
    nxt_vok      = vok_ff;
    nxt_done     = 1'b0;
    if (cmd_valid_in && !pend_vld_ff) begin
      nxt_pend     = cmd_in;
      nxt_pend_vld = 1'b1;
    end
    case (state_ff)
      BFA_ENG_IDLE: begin
        if (pend_vld_ff) begin
          nxt_run      = pend_ff;
          nxt_pend_vld = cmd_valid_in;
          nxt_state    = BFA_ENG_RUN;
          nxt_tmr      = (pend_ff.cmd == bfa_pkg::BFA_CMD_PROG) ?
                         bfa_pkg::TMR_W'(bfa_pkg::PROG_CYCLES) :
                         bfa_pkg::TMR_W'(bfa_pkg::ERASE_CYCLES);
        end
      end
      BFA_ENG_RUN: begin
        if (tmr_ff <= bfa_pkg::TMR_W'(1)) nxt_state = BFA_ENG_FIN;
        else nxt_tmr = tmr_ff - bfa_pkg::TMR_W'(1);
      end
      BFA_ENG_FIN: begin
        if (run_ff.cmd == bfa_pkg::BFA_CMD_VERIFY) nxt_vok = scan_ok;
        nxt_done  = 1'b1;
        nxt_state = BFA_ENG_IDLE;
      end
      default: nxt_state = BFA_ENG_IDLE;
    endcase
  end

  // Register the sequencer; the array effect at completion is applied in the block below.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      state_ff    <= BFA_ENG_IDLE;
      run_ff      <= '0;
      pend_ff     <= '0;
      pend_vld_ff <= 1'b0;
      tmr_ff      <= '0;
      vok_ff      <= 1'b0;
      done_ff     <= 1'b0;
    end else if (clk_en_in) begin
      state_ff    <= nxt_state;
      run_ff      <= nxt_run;
      pend_ff     <= nxt_pend;
      pend_vld_ff <= nxt_pend_vld;
      tmr_ff      <= nxt_tmr;
      vok_ff      <= nxt_vok;
      done_ff     <= nxt_done;
    end
  end

  // Array writes: programming only clears bits, erase sets them to one.
  always_ff @(posedge ref_clk_in) begin
    if (clk_en_in && state_ff == BFA_ENG_FIN) begin
      case (run_ff.cmd)
        bfa_pkg::BFA_CMD_PROG: begin
          mem[{run_ff.addr[15:1], 1'b0}] <= mem[{run_ff.addr[15:1], 1'b0}] &
                                            run_ff.data[15:8];
          mem[{run_ff.addr[15:1], 1'b1}] <= mem[{run_ff.addr[15:1], 1'b1}] &
                                            run_ff.data[7:0];
        end
        bfa_pkg::BFA_CMD_SECT_ERASE: begin
          for (int i = 0; i < bfa_pkg::SECTOR_BYTES; i++) begin
            mem[{run_ff.addr[15:9], 9'(i)}] <= bfa_pkg::ERASED_BYTE;
          end
        end
        bfa_pkg::BFA_CMD_MASS_ERASE: begin
          for (int i = 0; i < bfa_pkg::BLOCK_BYTES; i++) begin
            mem[i] <= bfa_pkg::ERASED_BYTE;
          end
        end
        default: ;
      endcase
    end
  end

  // Read data is the addressed byte and its successor, so a word needs one
  // array access; the successor wraps inside the block. Undefined while busy.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      rd_pair_out <= {bfa_pkg::ERASED_BYTE, bfa_pkg::ERASED_BYTE};
    end else if (clk_en_in) begin
      rd_pair_out <= {mem[rd_addr_in], mem[rd_addr_in + bfa_pkg::BLK_AW'(1)]};
    end
  end

  assign slot_free_out  = ~pend_vld_ff;
  assign busy_out       = (state_ff != BFA_ENG_IDLE) | pend_vld_ff;
  assign done_pulse_out = done_ff;
  assign verify_ok_out  = vok_ff;
endmodule : bfa_block_engine
`default_nettype wire

// ---- logic/bfa_flash_ctrl.sv ----
`timescale 1ns/100ps
`default_nettype none
module bfa_flash_ctrl (
  // Clock and reset
  input  wire logic                       ref_clk_in,
  input  wire logic                       reset_in,
  input  wire logic                       clk_en_in,
  // Read port; address bits 17:16 select the block
  input  wire logic                       rd_req_in,
  input  wire logic [17:0]                rd_addr_in,
  input  wire logic                       rd_word_in,
  output logic      [15:0]                rd_data_out,
  output logic                            rd_valid_out,
  // Three-step command entry
  input  wire logic                       step_addr_in,
  input  wire logic                       step_data_in,
  input  wire logic                       step_cmd_in,
  input  wire logic [15:0]                step_wdata_in,
  input  wire bfa_pkg::bfa_cmd_e          step_cmd_code_in,
  // Bank select and common controls
  input  wire logic [bfa_pkg::SEL_W-1:0]  bank_sel_in,
  input  wire logic                       done_ie_in,
  input  wire logic                       empty_ie_in,
  input  wire logic                       clear_done_in,
  // Status and interrupts
  output bfa_pkg::bfa_stat_s              bank_stat_out,
  output logic                            irq_done_out,
  output logic                            irq_empty_out
);
  localparam int NB = bfa_pkg::NUM_BLOCKS;

  // ==========================================================================
  // Command sequence tracking
  bfa_pkg::bfa_step_e            step_ff, nxt_step;
  logic [17:0]                   saddr_ff, nxt_saddr;
  logic [15:0]                   sdata_ff, nxt_sdata;
  logic                          serr_ff, nxt_serr;
  logic [NB-1:0]                 launch;
  bfa_pkg::bfa_cmd_s             launch_cmd;
  logic [NB-1:0]                 slot_free, busy, done_p, vok;
  logic [15:0]                   rpair [NB];
  logic [NB-1:0]                 done_st_ff, nxt_done_st;

  // Address, data, then command; any step out of order is flagged.
  always_comb begin
    nxt_step  = step_ff;
    nxt_saddr = saddr_ff;
    nxt_sdata = sdata_ff;
    nxt_serr  = serr_ff & ~clear_done_in;
    launch    = '0;
    launch_cmd.cmd  = step_cmd_code_in;
    launch_cmd.addr = saddr_ff[bfa_pkg::BLK_AW-1:0];
    launch_cmd.data = sdata_ff;
    case (step_ff)
      bfa_pkg::BFA_STEP_IDLE: begin
        if (step_addr_in) begin
          nxt_saddr = rd_addr_in;
          nxt_step  = bfa_pkg::BFA_STEP_DATA;
        end else if (step_data_in || step_cmd_in) nxt_serr = 1'b1;
      end
      bfa_pkg::BFA_STEP_DATA: begin
        if (step_data_in) begin
          nxt_sdata = step_wdata_in;
          nxt_step  = bfa_pkg::BFA_STEP_CMD;
        end else if (step_addr_in || step_cmd_in) begin
          nxt_serr = 1'b1;
          nxt_step = bfa_pkg::BFA_STEP_IDLE;
        end
      end
      bfa_pkg::BFA_STEP_CMD: begin
        if (step_cmd_in) begin
          if (slot_free[saddr_ff[17:16]])
            launch[saddr_ff[17:16]] = 1'b1;
          else nxt_serr = 1'b1;
          nxt_step = bfa_pkg::BFA_STEP_IDLE;
        end else if (step_addr_in || step_data_in) begin
          nxt_serr = 1'b1;
          nxt_step = bfa_pkg::BFA_STEP_IDLE;
        end
      end
      default: nxt_step = bfa_pkg::BFA_STEP_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      step_ff  <= bfa_pkg::BFA_STEP_IDLE;
      saddr_ff <= '0;
      sdata_ff <= '0;
      serr_ff  <= 1'b0;
    end else if (clk_en_in) begin
      step_ff  <= nxt_step;
      saddr_ff <= nxt_saddr;
      sdata_ff <= nxt_sdata;
      serr_ff  <= nxt_serr;
    end
  end

  // ==========================================================================
  // Four independent block engines
  for (genvar b = 0; b < NB; b++) begin : g_blk
    logic [bfa_pkg::BLK_AW-1:0] eng_raddr;
    // Second byte of a misaligned word comes from the next address.
    assign eng_raddr = rd_addr_in[bfa_pkg::BLK_AW-1:0];
    bfa_block_engine u_eng (
      .ref_clk_in     (ref_clk_in),
      .reset_in       (reset_in),
      .clk_en_in      (clk_en_in),
      .cmd_valid_in   (launch[b]),
      .cmd_in         (launch_cmd),
      .rd_addr_in     (eng_raddr),
      .rd_pair_out    (rpair[b]),
      .slot_free_out  (slot_free[b]),
      .busy_out       (busy[b]),
      .done_pulse_out (done_p[b]),
      .verify_ok_out  (vok[b])
    );
  end

  // ==========================================================================
  // Read sequencing: a misaligned word takes both bytes from one pair and answers a cycle later.
  typedef enum logic [1:0] {BFA_RD_IDLE, BFA_RD_FIRST, BFA_RD_SECOND} bfa_rd_e;
  bfa_rd_e        rst_ff, nxt_rst;
  logic [17:0]    raddr_ff, nxt_raddr;
  logic           rword_ff, nxt_rword, rmis_ff, nxt_rmis;
  logic [15:0]    hi_ff, nxt_hi;
  logic [15:0]    nxt_rdata;
  logic           nxt_rvalid;
  logic [15:0]    sel_pair;

  assign sel_pair = rpair[raddr_ff[17:16]];

  always_comb begin
    nxt_rst    = rst_ff;
    nxt_raddr  = raddr_ff;
    nxt_rword  = rword_ff;
    nxt_rmis   = rmis_ff;
    nxt_hi     = hi_ff;
    nxt_rdata  = rd_data_out;
    nxt_rvalid = 1'b0;
    case (rst_ff)
      BFA_RD_IDLE: begin
        if (rd_req_in) begin
          nxt_raddr = rd_addr_in;
          nxt_rword = rd_word_in;
          nxt_rmis  = rd_word_in & rd_addr_in[0];
          nxt_rst   = BFA_RD_FIRST;
        end
      end
      BFA_RD_FIRST: begin
        // Engines sampled this address last edge; the byte is ready now.
        // A misaligned word is held one more cycle to keep its three-cycle timing.
        if (rmis_ff) begin
          nxt_hi  = sel_pair;
          nxt_rst = BFA_RD_SECOND;
        end else begin
          nxt_rdata  = rword_ff ? sel_pair : {8'h00, sel_pair[15:8]};
          nxt_rvalid = 1'b1;
          nxt_rst    = BFA_RD_IDLE;
        end
      end
      BFA_RD_SECOND: begin
        nxt_rdata  = hi_ff;
        nxt_rvalid = 1'b1;
        nxt_rst    = BFA_RD_IDLE;
      end
      default: nxt_rst = BFA_RD_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      rst_ff       <= BFA_RD_IDLE;
      raddr_ff     <= '0;
      rword_ff     <= 1'b0;
      rmis_ff      <= 1'b0;
      hi_ff        <= '0;
      rd_data_out  <= '0;
      rd_valid_out <= 1'b0;
    end else if (clk_en_in) begin
      rst_ff       <= nxt_rst;
      raddr_ff     <= nxt_raddr;
      rword_ff     <= nxt_rword;
      rmis_ff      <= nxt_rmis;
      hi_ff        <= nxt_hi;
      rd_data_out  <= nxt_rdata;
      rd_valid_out <= nxt_rvalid;
    end
  end

  // ==========================================================================
  // Sticky completion flags, banked status and common interrupt enables.
  // A completion arriving with the clear keeps its flag set.
  bfa_pkg::bfa_stat_s nxt_stat;
  logic               nxt_irq_done, nxt_irq_empty;

  always_comb begin
    nxt_done_st            = (done_st_ff & ~{NB{clear_done_in}}) | done_p;
    nxt_stat.buf_empty     = slot_free[bank_sel_in];
    nxt_stat.done          = nxt_done_st[bank_sel_in];
    nxt_stat.busy          = busy[bank_sel_in];
    nxt_stat.verify_ok     = vok[bank_sel_in];
    nxt_stat.seq_error     = nxt_serr;
    nxt_irq_done           = done_ie_in & (|nxt_done_st);
    nxt_irq_empty          = empty_ie_in & (&slot_free);
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      done_st_ff    <= '0;
      bank_stat_out <= '0;
      irq_done_out  <= 1'b0;
      irq_empty_out <= 1'b0;
    end else if (clk_en_in) begin
      done_st_ff    <= nxt_done_st;
      bank_stat_out <= nxt_stat;
      irq_done_out  <= nxt_irq_done;
      irq_empty_out <= nxt_irq_empty;
    end
  end
endmodule : bfa_flash_ctrl
`default_nettype wire

// ---- pkg/bfa_pkg.sv ----
`default_nettype none
package bfa_pkg;
  // ==========================================================================
  // Array geometry
  localparam int NUM_BLOCKS      = 4;
  localparam int ROWS_PER_BLOCK  = 1024;
  localparam int BYTES_PER_ROW   = 64;
  localparam int ROWS_PER_SECTOR = 8;
  localparam int BLOCK_BYTES     = ROWS_PER_BLOCK * BYTES_PER_ROW;
  localparam int SECTOR_BYTES    = ROWS_PER_SECTOR * BYTES_PER_ROW;
  localparam int BLK_AW          = 16;
  localparam int SEL_W           = 2;
  localparam int SECT_AW         = 7;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // ==========================================================================
  // Command timing in clock cycles at 100 MHz
  localparam int PROG_TIME_NS    = 200;
  localparam int ERASE_TIME_NS   = 1000;
  localparam int CLK_PERIOD_NS   = 10;
  localparam int PROG_CYCLES     = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYCLES    = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W           = 16;
  // ==========================================================================
  // Commands and the three-step launch
  typedef enum logic [1:0] {
    BFA_CMD_PROG,
    BFA_CMD_SECT_ERASE,
    BFA_CMD_MASS_ERASE,
    BFA_CMD_VERIFY
  } bfa_cmd_e;

  typedef struct packed {
    bfa_cmd_e          cmd;
    logic [BLK_AW-1:0] addr;
    logic [15:0]       data;
  } bfa_cmd_s;

  typedef enum logic [1:0] {
    BFA_STEP_IDLE,
    BFA_STEP_DATA,
    BFA_STEP_CMD
  } bfa_step_e;

  // Status bits reported to the host; all but seq_error are per block.
  typedef struct packed {
    logic buf_empty;
    logic done;
    logic busy;
    logic verify_ok;
    logic seq_error;
  } bfa_stat_s;
endpackage : bfa_pkg
`default_nettype wire

// ---- tb/bfa_flash_ctrl_props.sv ----
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Port checks of the flash controller.
module bfa_flash_ctrl_props (
  // Clock and reset
  input wire logic                      ref_clk_in,
  input wire logic                      reset_in,
  input wire logic                      clk_en_in,
  // Read port
  input wire logic                      rd_req_in,
  input wire logic [17:0]               rd_addr_in,
  input wire logic                      rd_word_in,
  input wire logic                      rd_valid_out,
  // Status and common controls
  input wire logic [bfa_pkg::SEL_W-1:0] bank_sel_in,
  input wire logic                      done_ie_in,
  input wire logic                      empty_ie_in,
  input wire logic                      clear_done_in,
  input wire bfa_pkg::bfa_stat_s        bank_stat_out,
  input wire logic                      irq_done_out,
  input wire logic                      irq_empty_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  logic rd_busy_ff;
  logic nxt_rd_busy;
  logic rd_acc;
  logic rd_odd;
  // A request is only taken while no read is open; later ones are ignored.
  assign rd_acc = rd_req_in && clk_en_in && !rd_busy_ff;
  assign rd_odd = rd_word_in && rd_addr_in[0];
  // Next state of the open-read tracker.
  always_comb begin
    nxt_rd_busy = rd_busy_ff;
    if (reset_in) begin
      nxt_rd_busy = 1'b0;
    end else if (rd_acc) begin
      nxt_rd_busy = 1'b1;
    end else if (rd_valid_out) begin
      nxt_rd_busy = 1'b0;
    end
  end
  // Register of the tracker.
  always_ff @(posedge ref_clk_in) begin
    rd_busy_ff <= nxt_rd_busy;
  end
  chk_short_read_time: assert property (rd_acc && !rd_odd |-> ##1 !rd_valid_out ##1 rd_valid_out)
    else $error("short read answered at the wrong cycle");
  chk_odd_read_time: assert property (rd_acc && rd_odd |-> ##1 !rd_valid_out[*2] ##1 rd_valid_out)
    else $error("misaligned read answered at the wrong cycle");
  chk_valid_has_req: assert property (rd_valid_out |-> rd_busy_ff)
    else $error("read answer without a request");
  chk_done_irq_gate: assert property ($past(clk_en_in) && !$past(done_ie_in) |-> !irq_done_out)
    else $error("done interrupt while disabled");
  chk_empty_irq_gate: assert property ($past(clk_en_in) && !$past(empty_ie_in) |-> !irq_empty_out)
    else $error("empty interrupt while disabled");
  chk_freeze_state: assert property (!clk_en_in |=> $stable(bank_stat_out) && $stable(irq_done_out))
    else $error("status moved while clock enable low");
  chk_done_after_run: assert property ($rose(bank_stat_out.done) && $stable(bank_sel_in)
    && $past(bank_sel_in, 2) == bank_sel_in && $past(bank_sel_in, 3) == bank_sel_in
    |-> $past(bank_stat_out.busy) || $past(bank_stat_out.busy, 2))
    else $error("done rose without a running command");
  chk_done_sticky: assert property (bank_stat_out.done && !clear_done_in && !$past(clear_done_in)
    && $stable(bank_sel_in) |=> bank_stat_out.done)
    else $error("done flag dropped without a clear");
endmodule : bfa_flash_ctrl_props

bind bfa_flash_ctrl bfa_flash_ctrl_props u_props (
  .ref_clk_in(ref_clk_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
  .rd_req_in(rd_req_in), .rd_addr_in(rd_addr_in), .rd_word_in(rd_word_in),
  .rd_valid_out(rd_valid_out), .bank_sel_in(bank_sel_in), .done_ie_in(done_ie_in),
  .empty_ie_in(empty_ie_in), .clear_done_in(clear_done_in),
  .bank_stat_out(bank_stat_out), .irq_done_out(irq_done_out), .irq_empty_out(irq_empty_out)
);
`default_nettype wire

// ---- tb/bfa_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Host processor model: reads and three-step command launches.
module bfa_host_model (
  // Clock
  input  wire logic          ref_clk_in,
  // Read port
  output logic               rd_req_out,
  output logic [17:0]        rd_addr_out,
  output logic               rd_word_out,
  input  wire logic          rd_valid_in,
  input  wire logic [15:0]   rd_data_in,
  // Command steps
  output logic               step_addr_out,
  output logic               step_data_out,
  output logic               step_cmd_out,
  output logic [15:0]        step_wdata_out,
  output bfa_pkg::bfa_cmd_e  step_cmd_code_out
);
  // Everything quiet from time zero.
  initial begin
    {rd_req_out, rd_word_out, step_addr_out, step_data_out, step_cmd_out} = 5'h00;
    rd_addr_out = 18'h00000;
    step_wdata_out = 16'h0000;
    step_cmd_code_out = bfa_pkg::BFA_CMD_PROG;
  end
  // One read; callers only address idle blocks, so no wait state is needed.
  task automatic read(input logic [17:0] a, input logic w, output logic [15:0] d,
                      output int n);
    @(posedge ref_clk_in);
    #1;
    rd_req_out = 1'b1;
    rd_addr_out = a;
    rd_word_out = w;
    n = 0;
    do begin
      @(posedge ref_clk_in);
      #1;
      rd_req_out = 1'b0;
      n++;
    end while (rd_valid_in !== 1'b1 && n < 8);
    d = rd_data_in;
    rd_addr_out = ~a; // A stale address must not look valid.
  endtask : read
  // One strobe: 0 address, 1 data, 2 command.
  task automatic step(input int k, input logic [17:0] a, input logic [15:0] d,
                      input bfa_pkg::bfa_cmd_e c);
    @(posedge ref_clk_in);
    #1;
    {step_addr_out, step_data_out, step_cmd_out} = 3'b100 >> k;
    rd_addr_out = a;
    step_wdata_out = d;
    step_cmd_code_out = c;
  endtask : step
  // Drop all strobes.
  task automatic idle;
    @(posedge ref_clk_in);
    #1;
    {step_addr_out, step_data_out, step_cmd_out} = 3'b000;
  endtask : idle
  // Full launch; programs only words that callers erased first.
  task automatic launch(input logic [17:0] a, input logic [15:0] d,
                        input bfa_pkg::bfa_cmd_e c);
    step(0, a, d, c);
    step(1, a, d, c);
    step(2, a, d, c);
    idle();
  endtask : launch
endmodule : bfa_host_model
`default_nettype wire

// ---- tb/tb_banked_flash_array_control.sv ----
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Self-checking bench of the flash controller.
module tb_banked_flash_array_control;
  localparam int EW = bfa_pkg::ERASE_CYCLES + 20;
  localparam int PW = bfa_pkg::PROG_CYCLES + 20;
  logic ref_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic clk_en_in = 1'b1;
  logic [1:0] bank_sel_in = 2'h0;
  logic done_ie_in = 1'b0;
  logic empty_ie_in = 1'b0;
  logic clear_done_in = 1'b0;
  logic rd_req, rd_word, rd_valid, s_addr, s_data, s_cmd, irq_done, irq_empty;
  logic [17:0] rd_addr;
  logic [15:0] rd_data, wdata;
  bfa_pkg::bfa_cmd_e code;
  bfa_pkg::bfa_stat_s st;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  bfa_flash_ctrl dut (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
    .rd_req_in(rd_req), .rd_addr_in(rd_addr), .rd_word_in(rd_word),
    .rd_data_out(rd_data), .rd_valid_out(rd_valid), .step_addr_in(s_addr),
    .step_data_in(s_data), .step_cmd_in(s_cmd), .step_wdata_in(wdata),
    .step_cmd_code_in(code), .bank_sel_in(bank_sel_in), .done_ie_in(done_ie_in),
    .empty_ie_in(empty_ie_in), .clear_done_in(clear_done_in), .bank_stat_out(st),
    .irq_done_out(irq_done), .irq_empty_out(irq_empty));
  bfa_host_model host (
    .ref_clk_in(ref_clk_in), .rd_req_out(rd_req), .rd_addr_out(rd_addr),
    .rd_word_out(rd_word), .rd_valid_in(rd_valid), .rd_data_in(rd_data),
    .step_addr_out(s_addr), .step_data_out(s_data), .step_cmd_out(s_cmd),
    .step_wdata_out(wdata), .step_cmd_code_out(code));
  // Clock and hang guard; the whole run needs about a thousand cycles.
  always #5 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      $display("unexpected run length: expected below 20000, seen %0d", cycles);
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk
  task automatic finish_test;
    $display("checks %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test
  // Status is registered, so give it two edges after a new select.
  task automatic sel(input logic [1:0] b);
    @(posedge ref_clk_in);
    #1 bank_sel_in = b;
    repeat (2) @(posedge ref_clk_in);
    #1;
  endtask : sel
  task automatic wait_done(input logic [1:0] b, input int lim);
    int n;
    n = 0;
    sel(b);
    while (st.done !== 1'b1 && n < lim) begin
      @(posedge ref_clk_in);
      #1 n++;
    end
    chk("done flag", 16'h1, st.done);
  endtask : wait_done
  task automatic rd(input logic [17:0] a, input logic w, input logic [15:0] e);
    logic [15:0] d;
    int n;
    host.read(a, w, d, n);
    chk("read delay", (w && a[0]) ? 16'h3 : 16'h2, n[15:0]);
    chk("read data", e, w ? d : {8'h00, d[7:0]});
  endtask : rd
  // Clear old done flags first so that a wait cannot pass on a stale flag.
  task automatic cmd(input logic [17:0] a, input logic [15:0] d, input bfa_pkg::bfa_cmd_e c);
    @(posedge ref_clk_in);
    #1 clear_done_in = 1'b1;
    @(posedge ref_clk_in);
    #1 clear_done_in = 1'b0;
    host.launch(a, d, c);
  endtask : cmd
  task automatic t_erase_program;
    cmd(18'h00000, 16'h0000, bfa_pkg::BFA_CMD_MASS_ERASE);
    wait_done(2'h0, EW);
    rd(18'h0ffff, 1'b0, 16'h00ff);
    rd(18'h00101, 1'b1, 16'hffff);
    cmd(18'h00010, 16'ha55a, bfa_pkg::BFA_CMD_PROG);
    wait_done(2'h0, PW);
    rd(18'h00011, 1'b0, 16'h005a);
    rd(18'h00010, 1'b1, 16'ha55a);
  endtask : t_erase_program
  // Programmed words on both sides of sector one, then erase that sector.
  task automatic t_sector;
    cmd(18'h001fe, 16'h1234, bfa_pkg::BFA_CMD_PROG);
    wait_done(2'h0, PW);
    cmd(18'h00400, 16'h00ff, bfa_pkg::BFA_CMD_PROG);
    wait_done(2'h0, PW);
    cmd(18'h00200, 16'h0f0f, bfa_pkg::BFA_CMD_PROG);
    wait_done(2'h0, PW);
    cmd(18'h00200, 16'h0000, bfa_pkg::BFA_CMD_SECT_ERASE);
    wait_done(2'h0, EW);
    rd(18'h001fe, 1'b0, 16'h0012);
    rd(18'h00200, 1'b0, 16'h00ff);
    rd(18'h00400, 1'b0, 16'h0000);
  endtask : t_sector
  task automatic t_parallel;
    cmd(18'h00000, 16'h0000, bfa_pkg::BFA_CMD_MASS_ERASE);
    for (int b = 1; b < 4; b++) host.launch({b[1:0], 16'h0000}, 16'h0000, bfa_pkg::BFA_CMD_MASS_ERASE);
    for (int b = 0; b < 4; b++) begin
      sel(b[1:0]);
      chk("busy", 16'h1, st.busy);
    end
    clk_en_in = 1'b0;
    repeat (EW) @(posedge ref_clk_in);
    #1 chk("frozen busy", 16'h1, st.busy);
    clk_en_in = 1'b1;
    for (int b = 0; b < 4; b++) wait_done(b[1:0], EW);
    done_ie_in = 1'b1;
    sel(2'h0);
    chk("done irq", 16'h1, irq_done);
    clear_done_in = 1'b1;
    sel(2'h3);
    clear_done_in = 1'b0;
    done_ie_in = 1'b0;
    chk("cleared irq", 16'h0, irq_done);
    chk("cleared done", 16'h0, st.done);
  endtask : t_parallel
  task automatic t_pending;
    empty_ie_in = 1'b1;
    cmd(18'h10000, 16'h0000, bfa_pkg::BFA_CMD_SECT_ERASE);
    host.launch(18'h10200, 16'h0000, bfa_pkg::BFA_CMD_SECT_ERASE);
    sel(2'h1);
    chk("slot free", 16'h0, st.buf_empty);
    chk("empty irq", 16'h0, irq_empty);
    host.launch(18'h10400, 16'h0000, bfa_pkg::BFA_CMD_SECT_ERASE);
    sel(2'h1);
    chk("full slot error", 16'h1, st.seq_error);
    repeat (2 * EW) @(posedge ref_clk_in);
    #1 chk("slot free", 16'h1, st.buf_empty);
    chk("empty irq", 16'h1, irq_empty);
    empty_ie_in = 1'b0;
    cmd(18'h10000, 16'h0000, bfa_pkg::BFA_CMD_VERIFY);
    wait_done(2'h1, EW);
    chk("verified", 16'h1, st.verify_ok);
    @(posedge ref_clk_in);
    #1 clear_done_in = 1'b1;
    @(posedge ref_clk_in);
    #1 clear_done_in = 1'b0;
    host.step(2, 18'h20000, 16'h0000, bfa_pkg::BFA_CMD_PROG);
    host.idle();
    sel(2'h2);
    chk("order error", 16'h1, st.seq_error);
    chk("no run", 16'h0, st.busy);
  endtask : t_pending
  // Main sequence.
  initial begin
    repeat (3) @(posedge ref_clk_in);
    #1 chk("status in reset", 16'h0, {11'h000, st});
    reset_in = 1'b0;
    sel(2'h0);
    chk("slot free", 16'h1, st.buf_empty);
    t_erase_program();
    t_sector();
    t_parallel();
    t_pending();
    finish_test();
  end
endmodule : tb_banked_flash_array_control
`default_nettype wire
